// ### hdl/power_window_timer_control.sv
`timescale 1ns/1ps
`include "pwin_regs.svh"

module power_window_timer_control #(
  parameter int unsigned TICK_CYC = `PW_TICK_CYC
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // vehicle inputs, asynchronous
  input wire logic IGN_I,
  input wire logic DOOR_I,
  input wire logic SW_UP_I,
  input wire logic SW_DN_I,
  input wire logic OVERCUR_I,
  // relay, supply and forced-mode outputs
  output logic MOTOR_FWD_O,
  output logic MOTOR_REV_O,
  output logic WIN_RELAY_O,
  output logic SW_SUPPLY_O,
  output logic FORCED_O
);
  import pwin_pkg::*;

  if (TICK_CYC < 1)
  begin : g_bad_tick
    $error("TICK_CYC must be at least one");
  end

  state_t q;
  state_t d;

  logic tick;
  logic ign;
  logic door;
  logic up;
  logic dn;
  logic oc;
  logic one;
  logic enabled;
  logic last6;
  logic new_press;
  logic long_hit;
  logic short_rel;
  logic rel_up;
  logic moving;

  // true when exactly one direction is pressed
  function automatic logic one_dir(input logic [1:0] sw);
    return sw[1] ^ sw[0];
  endfunction : one_dir

  always_comb
  begin
    d = q;
    // two-stage synchronisers
    d.sync1 = {OVERCUR_I, SW_DN_I, SW_UP_I, DOOR_I, IGN_I};
    d.sync2 = q.sync1;
    ign = q.sync2[`PW_IN_IGN];
    door = q.sync2[`PW_IN_DOOR];
    up = q.sync2[`PW_IN_UP];
    dn = q.sync2[`PW_IN_DN];
    oc = q.sync2[`PW_IN_OC];

    // base tick prescaler
    tick = (q.pre == 32'(TICK_CYC - 1));
    d.pre = tick ? 32'h0 : q.pre + 32'h1;

    d.ign_q = ign;
    d.door_q = door;
    d.sw_q = {up, dn};
    moving = (q.mode != MODE_IDLE);

    // retained-power timer
    if (ign)
    begin
      d.retain = 16'h0;
    end
    else if (q.ign_q)
    begin
      d.retain = `PW_RETAIN_TICKS;
    end
    else if (oc && q.rev && q.retain != 16'h0)
    begin
      d.retain = `PW_RETAIN_TICKS;
    end
    else if (door != q.door_q && q.retain != 16'h0)
    begin
      d.retain = `PW_RETAIN_TICKS;
    end
    else if (tick && q.retain != 16'h0)
    begin
      d.retain = q.retain - 16'h1;
    end
    enabled = ign || (q.retain != 16'h0);
    last6 = !ign && q.retain != 16'h0 && q.retain <= `PW_LAST_TICKS;

    // press duration measurement
    one = one_dir({up, dn});
    new_press = one && ({up, dn} != q.sw_q);
    if (!one || new_press)
    begin
      d.press = 16'h0;
    end
    else if (tick && q.press != `PW_LONG_TICKS)
    begin
      d.press = q.press + 16'h1;
    end
    long_hit = one && !new_press && tick && !q.held &&
               (q.press == `PW_LONG_TICKS - 16'h1);
    short_rel = one_dir(q.sw_q) && !up && !dn && !q.held &&
                (q.press < `PW_LONG_TICKS);
    rel_up = q.sw_q[1];
    if (!up && !dn)
    begin
      d.held = 1'b0;
    end

    // movement run time
    if (moving && tick)
    begin
      d.run = q.run + 16'h1;
    end

    unique case (q.mode)
      MODE_IDLE:
      begin
        if (long_hit)
        begin
          d.mode = MODE_AUTO;
          d.dir_up = up;
          d.forced = last6 && up;
          d.run = 16'h0;
        end
        else if (short_rel)
        begin
          d.mode = MODE_STEP;
          d.dir_up = rel_up;
          d.step = `PW_STEP_TICKS;
          d.run = 16'h0;
        end
      end
      MODE_STEP:
      begin
        if ((up && dn) || (new_press && up != q.dir_up))
        begin
          d.mode = MODE_IDLE;
          d.held = 1'b1;
        end
        else if (long_hit)
        begin
          d.mode = MODE_AUTO;
          d.dir_up = up;
          d.forced = last6 && up;
        end
        else if (short_rel && rel_up == q.dir_up)
        begin
          d.step = q.step + `PW_STEP_TICKS;
        end
        else if (tick)
        begin
          if (q.step <= 16'h1)
          begin
            d.mode = MODE_IDLE;
          end
          d.step = q.step - 16'h1;
        end
      end
      MODE_AUTO:
      begin
        if (new_press || (up && dn))
        begin
          d.mode = MODE_IDLE;
          d.held = 1'b1;
        end
      end
    endcase

    // stop conditions shared by step and automatic travel
    if (moving)
    begin
      if (q.run >= `PW_RUN_MAX_TICKS)
      begin
        d.mode = MODE_IDLE;
      end
      if (oc && !q.forced && q.run >= `PW_OC_MIN_TICKS)
      begin
        d.mode = MODE_IDLE;
      end
    end
    if (!enabled)
    begin
      d.mode = MODE_IDLE;
    end
    if (d.mode == MODE_IDLE)
    begin
      d.forced = 1'b0;
      d.step = 16'h0;
    end

    // relay drive: exclusive polarity
    d.fwd = (d.mode != MODE_IDLE) && d.dir_up;
    d.rev = (d.mode != MODE_IDLE) && !d.dir_up;
    d.relay = !ign && d.retain != 16'h0;
    d.supply = ign;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      q <= '{mode: MODE_IDLE, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign MOTOR_FWD_O = q.fwd;
  assign MOTOR_REV_O = q.rev;
  assign WIN_RELAY_O = q.relay;
  assign SW_SUPPLY_O = q.supply;
  assign FORCED_O = q.forced;

endmodule : power_window_timer_control

// ### hdl/pwin_regs.svh
`ifndef PWIN_REGS_SVH
`define PWIN_REGS_SVH

// clock and base tick
`define PW_CLK_NS 5
`define PW_TICK_NS 1000000
`define PW_TICK_CYC (`PW_TICK_NS / `PW_CLK_NS)
`define PW_TICK_MS 1

// durations in milliseconds
`define PW_RETAIN_MS 30000
`define PW_LAST_MS 6000
`define PW_LONG_MS 300
`define PW_OC_MIN_MS 700
`define PW_RUN_MAX_MS 6000
`define PW_STEP_MS 500

// durations in base ticks
`define PW_RETAIN_TICKS 16'(`PW_RETAIN_MS / `PW_TICK_MS)
`define PW_LAST_TICKS 16'(`PW_LAST_MS / `PW_TICK_MS)
`define PW_LONG_TICKS 16'(`PW_LONG_MS / `PW_TICK_MS)
`define PW_OC_MIN_TICKS 16'(`PW_OC_MIN_MS / `PW_TICK_MS)
`define PW_RUN_MAX_TICKS 16'(`PW_RUN_MAX_MS / `PW_TICK_MS)
`define PW_STEP_TICKS 16'(`PW_STEP_MS / `PW_TICK_MS)

// synchroniser bit positions
`define PW_IN_IGN 0
`define PW_IN_DOOR 1
`define PW_IN_UP 2
`define PW_IN_DN 3
`define PW_IN_OC 4
`define PW_IN_W 5

`endif

// ### hdl/pwin_pkg.sv
package pwin_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_STEP,
    MODE_AUTO
  } mode_t;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [31:0] pre;
    logic ign_q;
    logic door_q;
    logic [1:0] sw_q;
    logic [15:0] retain;
    logic [15:0] press;
    logic [15:0] run;
    logic [15:0] step;
    mode_t mode;
    logic dir_up;
    logic forced;
    logic held;
    logic fwd;
    logic rev;
    logic relay;
    logic supply;
  } state_t;

endpackage : pwin_pkg

// ### sim/pwin_props.sv
`timescale 1ns/1ps
module pwin_props #(
  parameter int unsigned TICK_CYC = 200000
) (
  // clock, reset and inputs
  input wire logic MCLK_I, RST_N_I, IGN_I, DOOR_I, SW_UP_I, SW_DN_I,
  input wire logic OVERCUR_I,
  // outputs
  input wire logic MOTOR_FWD_O, MOTOR_REV_O, WIN_RELAY_O, SW_SUPPLY_O,
  input wire logic FORCED_O
);
  localparam int unsigned LIM = 6001 * TICK_CYC + 4;
  logic [31:0] run_q;
  logic on_w;
  assign on_w = MOTOR_FWD_O || MOTOR_REV_O;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // cycles of uninterrupted motor drive
  always_ff @(posedge MCLK_I)
    run_q <= (!RST_N_I || !on_w) ? 32'h0 : run_q + 32'h1;
  excl_drive_a: assert property (!(MOTOR_FWD_O && MOTOR_REV_O))
    else $error("both motor directions driven");
  supply_on_a: assert property ($rose(IGN_I) |-> ##[2:4] SW_SUPPLY_O)
    else $error("switch supply missing after ignition on");
  relay_on_a: assert property ($fell(IGN_I) |-> ##[2:4] WIN_RELAY_O)
    else $error("relay missing after ignition off");
  relay_ign_a: assert property (SW_SUPPLY_O |-> !WIN_RELAY_O)
    else $error("relay on with ignition on");
  reset_off_a: assert property (disable iff (1'b0)
    !RST_N_I |=> !(on_w || WIN_RELAY_O)) else $error("output on after reset");
  no_power_a: assert property (
    (!SW_SUPPLY_O && !WIN_RELAY_O)[*3] |-> !on_w)
    else $error("motor runs without power");
  start_power_a: assert property (
    $rose(on_w) |-> SW_SUPPLY_O || WIN_RELAY_O)
    else $error("motor started without power");
  run_max_a: assert property (run_q <= LIM)
    else $error("motor ran past run limit");
  forced_up_a: assert property (FORCED_O |-> !MOTOR_REV_O)
    else $error("forced mode while lowering");
  cover property ($rose(MOTOR_FWD_O));
  cover property ($rose(MOTOR_REV_O));
  cover property ($rose(FORCED_O));
endmodule : pwin_props

bind power_window_timer_control pwin_props #(.TICK_CYC(TICK_CYC)) props (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .IGN_I(IGN_I), .DOOR_I(DOOR_I),
  .SW_UP_I(SW_UP_I), .SW_DN_I(SW_DN_I), .OVERCUR_I(OVERCUR_I),
  .MOTOR_FWD_O(MOTOR_FWD_O), .MOTOR_REV_O(MOTOR_REV_O),
  .WIN_RELAY_O(WIN_RELAY_O), .SW_SUPPLY_O(SW_SUPPLY_O), .FORCED_O(FORCED_O));

// ### sim/pwin_motor_model.sv
`timescale 1ns/1ps
module pwin_motor_model (
  input wire logic fwd_i,
  input wire logic rev_i,
  input wire logic stall_i,
  output logic oc_o
);
  // a stalled motor draws over-limit current only while driven
  assign oc_o = stall_i && (fwd_i || rev_i);
endmodule : pwin_motor_model

// ### sim/power_window_timer_control_tb.sv
`timescale 1ns/1ps
module power_window_timer_control_tb;
  localparam int TC = 2;
  logic clk = 0, rst_n = 0, ign = 0, door = 0, up = 0, dn = 0, stall = 0;
  logic oc, fwd, rev, rly, sup, frc;
  int error_cnt = 0;
  int compares = 0;
  power_window_timer_control #(.TICK_CYC(TC)) dut (.MCLK_I(clk),
    .RST_N_I(rst_n), .IGN_I(ign), .DOOR_I(door), .SW_UP_I(up), .SW_DN_I(dn),
    .OVERCUR_I(oc), .MOTOR_FWD_O(fwd), .MOTOR_REV_O(rev), .WIN_RELAY_O(rly),
    .SW_SUPPLY_O(sup), .FORCED_O(frc));
  pwin_motor_model mdl (.fwd_i(fwd), .rev_i(rev), .stall_i(stall), .oc_o(oc));
  initial forever #2.5 clk = ~clk;
  // wait a number of ticks, ending just after a falling edge
  task automatic w(input int t);
    repeat (t * TC) @(negedge clk);
  endtask : w
  task automatic chk(input string n, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask : chk
  task automatic press(input logic u, input int t);
    up = u;
    dn = !u;
    w(t);
    up = 0;
    dn = 0;
  endtask : press
  task automatic t_supply;
    ign = 1;
    w(2);
    chk("supply", 1, sup);
    chk("relay", 0, rly);
  endtask : t_supply
  task automatic t_step;
    press(1, 100);
    w(480);
    chk("fwd", 1, fwd);
    chk("rev", 0, rev);
    w(40);
    chk("fwd", 0, fwd);
  endtask : t_step
  task automatic t_multi;
    press(0, 50);
    w(50);
    press(0, 50);
    w(850);
    chk("rev", 1, rev);
    w(200);
    chk("rev", 0, rev);
  endtask : t_multi
  task automatic t_auto;
    press(1, 310);
    w(500);
    chk("fwd", 1, fwd);
    press(1, 20);
    w(2);
    chk("fwd", 0, fwd);
    w(600);
    chk("fwd", 0, fwd);
  endtask : t_auto
  task automatic t_runmax;
    press(0, 310);
    w(5800);
    chk("rev", 1, rev);
    w(300);
    chk("rev", 0, rev);
  endtask : t_runmax
  task automatic t_oc;
    stall = 1;
    press(1, 310);
    w(300);
    chk("fwd", 1, fwd);
    w(450);
    chk("fwd", 0, fwd);
    stall = 0;
  endtask : t_oc
  task automatic t_retain;
    ign = 0;
    w(2);
    chk("relay", 1, rly);
    chk("supply", 0, sup);
    w(1000);
    door = 1;
    w(25000);
    stall = 1;
    press(1, 310);
    chk("forced", 1, frc);
    w(800);
    chk("fwd", 1, fwd);
    stall = 0;
    press(1, 20);
    w(3400);
    chk("relay", 1, rly);
    w(600);
    chk("relay", 0, rly);
    press(1, 100);
    w(10);
    chk("fwd", 0, fwd);
  endtask : t_retain
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    w(1);
    chk("fwd", 0, fwd);
    chk("relay", 0, rly);
    t_supply;
    t_step;
    t_multi;
    t_auto;
    t_runmax;
    t_oc;
    t_retain;
    end_of_test;
  end
  initial
  begin
    #460000;
    error_cnt++;
    end_of_test;
  end
endmodule : power_window_timer_control_tb
